//--- dmc_cfg.svh
/*
 * Constants for the channel mode and configuration block: port addresses,
 * field positions, reset values and cycle lengths in bus clocks.
 * Assumes it is included by bare name and defines nothing but macros.
 */
`ifndef DMC_CFG_SVH
`define DMC_CFG_SVH

// Write-only port addresses on the 16-bit I/O space
`define DMC_CMD_LO_ADDR 16'h0008
`define DMC_CMD_HI_ADDR 16'h00D0
`define DMC_MODE_LO_ADDR 16'h000B
`define DMC_MODE_HI_ADDR 16'h00D6
`define DMC_EXT_LO_ADDR 16'h040B
`define DMC_EXT_HI_ADDR 16'h04D6

// Group command field positions
`define DMC_CMD_ACKHI_BIT 7
`define DMC_CMD_SENSE_BIT 6
`define DMC_CMD_ROT_BIT 4
`define DMC_CMD_DIS_BIT 2

// Reset values of the per-channel data size field
`define DMC_SIZE_LO_RST 2'h0
`define DMC_SIZE_HI_RST 2'h1

// Transfer cycle lengths in bus clocks
`define DMC_CYC_COMPAT_SINGLE 4'h9
`define DMC_CYC_COMPAT_REP 4'h8
`define DMC_CYC_A_REP 4'h6
`define DMC_CYC_B_REP 4'h5
`define DMC_CYC_F_REP 4'h3
`define DMC_CYC_FAST_SINGLE_EXTRA 4'h1

`endif

//--- dmc_pkg.sv
/*
 * Types shared by the channel configuration block and its testbench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dmc_pkg;

    // Transfer mode field
    typedef enum logic [1:0] {
        MD_DEMAND = 2'b00,
        MD_SINGLE = 2'b01,
        MD_BLOCK = 2'b10,
        MD_CASCADE = 2'b11
    } dmc_mode_e;

    // Transfer type field; code 11 must never be programmed
    typedef enum logic [1:0] {
        TT_VERIFY = 2'b00,
        TT_WRITE = 2'b01,
        TT_READ = 2'b10,
        TT_ILLEGAL = 2'b11
    } dmc_type_e;

    // Cycle timing field
    typedef enum logic [1:0] {
        TM_COMPAT = 2'b00,
        TM_A = 2'b01,
        TM_B = 2'b10,
        TM_F = 2'b11
    } dmc_timing_e;

    // Stored settings of one channel
    typedef struct packed {
        dmc_mode_e mode;
        logic addrDecr;
        logic autoInit;
        dmc_type_e xtype;
        logic eopIn;
        dmc_timing_e timing;
        logic [1:0] dataSize;
    } dmc_chcfg_s;

    // One port write as it travels through the FIFO
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } dmc_wr_s;

endpackage : dmc_pkg

//--- dmc_fifo.sv
/*
 * Shifting FIFO with registered head word, registered ready and valid.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
module dmc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    input wire logic outReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH]; // Entry 0 is the head
    logic [CW-1:0] count_ff; // Words held
    logic inReady_ff;
    logic outValid_ff;
    wire push = inValid && inReady_ff;
    wire pop = outValid_ff && outReady;
    wire [CW-1:0] nxt_count = count_ff + CW'(push) - CW'(pop);
    // Pushed word lands behind the last one, one lower if the head leaves
    wire [CW-1:0] wrIdx = pop ? count_ff - CW'(1) : count_ff;

    assign inReady = inReady_ff;
    assign outValid = outValid_ff;
    assign outData = mem_ff[0];

    // Occupancy and the two registered handshake flags
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
            inReady_ff <= 1'b1;
            outValid_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            inReady_ff <= (nxt_count != FULL);
            outValid_ff <= (nxt_count != '0);
        end
    end

    // Each entry loads the new word or its upper neighbour on a pop
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        wire [WIDTH-1:0] upper;
        if (i == DEPTH - 1) begin : g_top
            assign upper = '0;
        end else begin : g_mid
            assign upper = mem_ff[i+1];
        end
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                mem_ff[i] <= '0;
            end else if (push && wrIdx == CW'(i)) begin
                mem_ff[i] <= inData;
            end else if (pop) begin
                mem_ff[i] <= upper;
            end
        end
    end

endmodule : dmc_fifo

//--- dmc_channel_cfg.sv
/*
 * Group command, channel mode and extended mode registers of a two-group,
 * eight-slot DMA engine, plus the decoded controls they steer.
 * Assumes port writes arrive from the host bridge on ref_clk, that the
 * arbiter and transfer engine share ref_clk, and that request and
 * end-of-process pins come from outside and are synchronised here.
 */
`timescale 1ns/10ps
`include "dmc_cfg.svh"

// Operation
// - Request sense bit 0 high active, 1 low
// - Priority bit picks fixed or rotating arbitration
// - Enable bit 1 disables group, reset enables
// - Upper group off also turns lower off
// - Mode write low bits select channel only
// - Reset or master clear zeroes channel mode
// - Channel four is always cascade
// - Mode field demand single block cascade
// - Direction bit 0 increments, 1 decrements
// - Autoinit restores base registers at terminal count
// - Type field verify write read, 11 illegal
// - Verify makes addresses but no command strobes
// - Cascade channels ignore the type field
// - Extended write low bits select channel only
// - Fast timing only to main memory
// - Extended settings loaded by reset only
// - Lower bytes, upper words, compatible, eop out
// - Per-channel bit sets end-of-process direction
// - Switch eop direction when acknowledge moves
// - Compatible timing nine single, eight repeated
// - Type A repeated cycles six clocks
// - Type B repeated cycles five clocks
// - Type F repeated cycles three clocks
// - Acknowledge polarity bit, low active default
module dmc_channel_cfg #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Port write from the host side
    input wire logic ioWrValid,
    input wire logic [15:0] ioAddr,
    input wire logic [7:0] ioWrData,
    output logic ioWrReady,
    input wire logic masterClr,
    input wire logic xferBusy,
    // Request pins and acknowledge grants
    input wire logic [7:0] dreqPin,
    input wire logic [7:0] ackGrant,
    output logic [7:0] chReq,
    output logic [7:0] ackPin,
    output logic [1:0] grpRotate,
    output logic [1:0] grpEnable,
    // Channel settings for the transfer engine
    output dmc_pkg::dmc_chcfg_s [7:0] chCfg,
    output logic [7:0] strobeEn,
    input wire logic [7:0] tcPulse,
    output logic [7:0] reloadPulse,
    // End-of-process pin as three signals
    input wire logic eopPinIn,
    output logic eopOut,
    output logic eopOe_n,
    // Cycle length of the channel being served
    input wire logic [2:0] actCh,
    input wire logic actRepeat,
    input wire logic actIsaMem,
    output logic [3:0] cycleLen
);

    // Drained write and its handshake
    dmc_pkg::dmc_wr_s fifoIn;
    dmc_pkg::dmc_wr_s wr;
    logic wrValid;
    wire wrPop = wrValid && !xferBusy; // Engine stalls config changes mid-cycle

    // Synchronisers; the meta stages feed only the second stages
    logic [7:0] reqMeta_ff;
    logic [7:0] reqSync_ff;
    logic eopMeta_ff;
    logic eopSync_ff;
    logic eopPrev_ff;

    // Group command state, index 0 lower group, 1 upper group
    logic [1:0] ackHigh_ff;
    logic [1:0] senseLow_ff;
    logic [1:0] rotate_ff;
    logic [1:0] disable_ff;
    logic [1:0] grpEnable_ff;

    // Per-channel state and registered outputs
    dmc_pkg::dmc_chcfg_s [7:0] cfg_ff;
    logic [7:0] chReq_ff;
    logic [7:0] ackPin_ff;
    logic [7:0] strobeEn_ff;
    logic [7:0] reload_ff;
    logic eopOut_ff;
    logic eopOe_n_ff;
    logic [2:0] actChPrev_ff;
    logic [3:0] cycleLen_ff;

    assign fifoIn = '{addr: ioAddr, data: ioWrData};

    // Writes are queued so a burst from the host does not wait on the engine
    dmc_fifo #(
        .WIDTH($bits(dmc_pkg::dmc_wr_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .inValid(ioWrValid),
        .inData(fifoIn),
        .inReady(ioWrReady),
        .outReady(!xferBusy),
        .outValid(wrValid),
        .outData(wr)
    );

    // Two-stage synchronisers for the pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reqMeta_ff <= 8'h00;
            reqSync_ff <= 8'h00;
            eopMeta_ff <= 1'b0;
            eopSync_ff <= 1'b0;
            eopPrev_ff <= 1'b0;
        end else begin
            reqMeta_ff <= dreqPin;
            reqSync_ff <= reqMeta_ff;
            eopMeta_ff <= eopPinIn;
            eopSync_ff <= eopMeta_ff;
            eopPrev_ff <= eopSync_ff;
        end
    end

    // Rising edge of a slave-driven end-of-process
    wire eopRise = eopSync_ff && !eopPrev_ff;

    // Upper group off pulls the lower group down too, it hangs off channel four
    wire [1:0] nxt_grpEnable = {!disable_ff[1], !disable_ff[0] && !disable_ff[1]};

    // Group command registers
    for (genvar g = 0; g < 2; g++) begin : g_grp
        localparam logic [15:0] CMD_ADDR = (g == 0) ? `DMC_CMD_LO_ADDR : `DMC_CMD_HI_ADDR;
        wire wrCmd = wrPop && (wr.addr == CMD_ADDR);
        // Reserved bits 5, 3, 1 and 0 are simply not stored
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                ackHigh_ff[g] <= 1'b0;
                senseLow_ff[g] <= 1'b0;
                rotate_ff[g] <= 1'b0;
                disable_ff[g] <= 1'b0;
            end else if (masterClr) begin
                ackHigh_ff[g] <= 1'b0;
                senseLow_ff[g] <= 1'b0;
                rotate_ff[g] <= 1'b0;
                disable_ff[g] <= 1'b0;
            end else if (wrCmd) begin
                ackHigh_ff[g] <= wr.data[`DMC_CMD_ACKHI_BIT];
                senseLow_ff[g] <= wr.data[`DMC_CMD_SENSE_BIT];
                rotate_ff[g] <= wr.data[`DMC_CMD_ROT_BIT];
                disable_ff[g] <= wr.data[`DMC_CMD_DIS_BIT];
            end
        end
    end

    // Per-channel mode and extended mode registers
    for (genvar i = 0; i < 8; i++) begin : g_ch
        localparam int G = i / 4;
        localparam logic [1:0] SUB = 2'(i % 4);
        localparam logic [15:0] MODE_ADDR = (G == 0) ? `DMC_MODE_LO_ADDR : `DMC_MODE_HI_ADDR;
        localparam logic [15:0] EXT_ADDR = (G == 0) ? `DMC_EXT_LO_ADDR : `DMC_EXT_HI_ADDR;
        localparam logic [1:0] SIZE_RST = (G == 0) ? `DMC_SIZE_LO_RST : `DMC_SIZE_HI_RST;
        // Channel four is locked to cascade, whatever software writes
        localparam dmc_pkg::dmc_mode_e MODE_RST =
            (i == 4) ? dmc_pkg::MD_CASCADE : dmc_pkg::MD_DEMAND;
        // Low two data bits pick the channel and are never stored
        wire selHit = (wr.data[1:0] == SUB);
        wire wrMode = wrPop && (wr.addr == MODE_ADDR) && selHit;
        wire wrExt = wrPop && (wr.addr == EXT_ADDR) && selHit;
        wire dmc_pkg::dmc_mode_e wrModeVal =
            (i == 4) ? dmc_pkg::MD_CASCADE : dmc_pkg::dmc_mode_e'(wr.data[7:6]);

        // Mode fields: cleared by reset or master clear
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cfg_ff[i].mode <= MODE_RST;
                cfg_ff[i].addrDecr <= 1'b0;
                cfg_ff[i].autoInit <= 1'b0;
                cfg_ff[i].xtype <= dmc_pkg::TT_VERIFY;
            end else if (masterClr) begin
                cfg_ff[i].mode <= MODE_RST;
                cfg_ff[i].addrDecr <= 1'b0;
                cfg_ff[i].autoInit <= 1'b0;
                cfg_ff[i].xtype <= dmc_pkg::TT_VERIFY;
            end else if (wrMode) begin
                cfg_ff[i].mode <= wrModeVal;
                cfg_ff[i].addrDecr <= wr.data[5];
                cfg_ff[i].autoInit <= wr.data[4];
                cfg_ff[i].xtype <= dmc_pkg::dmc_type_e'(wr.data[3:2]);
            end
        end

        // Extended fields: only reset loads defaults, master clear leaves them
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cfg_ff[i].eopIn <= 1'b0;
                cfg_ff[i].timing <= dmc_pkg::TM_COMPAT;
                cfg_ff[i].dataSize <= SIZE_RST;
            end else if (wrExt) begin
                cfg_ff[i].eopIn <= wr.data[6];
                cfg_ff[i].timing <= dmc_pkg::dmc_timing_e'(wr.data[5:4]);
                cfg_ff[i].dataSize <= wr.data[3:2]; // Bit 7 reserved, dropped
            end
        end

        // Decoded per-channel controls
        wire reqLevel = reqSync_ff[i] ^ senseLow_ff[G];
        wire nxt_req = reqLevel && grpEnable_ff[G];
        wire nxt_ack = ackHigh_ff[G] ? ackGrant[i] : !ackGrant[i];
        // Verify moves no data, and a cascaded slave drives its own strobes
        wire nxt_strobe = (cfg_ff[i].mode != dmc_pkg::MD_CASCADE) &&
                          (cfg_ff[i].xtype != dmc_pkg::TT_VERIFY);
        // Terminal count, or a slave end-of-process while this channel owns the bus
        wire endEvt = tcPulse[i] || (cfg_ff[i].eopIn && ackGrant[i] && eopRise);
        wire nxt_reload = cfg_ff[i].autoInit && endEvt;

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                chReq_ff[i] <= 1'b0;
                ackPin_ff[i] <= 1'b1;
                strobeEn_ff[i] <= 1'b0;
                reload_ff[i] <= 1'b0;
            end else begin
                chReq_ff[i] <= nxt_req;
                ackPin_ff[i] <= nxt_ack;
                strobeEn_ff[i] <= nxt_strobe;
                reload_ff[i] <= nxt_reload;
            end
        end
    end

    // End-of-process direction follows the acknowledged channel; it only
    // changes when the grant moves, so a mid-transfer write cannot flip it
    wire ackMoved = (actCh != actChPrev_ff);
    wire nxt_eopOe_n = ackMoved ? cfg_ff[actCh].eopIn : eopOe_n_ff;
    // While driving, the pin idles low so an overlap with a slave is harmless
    wire nxt_eopOut = !nxt_eopOe_n && tcPulse[actCh];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            actChPrev_ff <= 3'h0;
            eopOe_n_ff <= 1'b0;
            eopOut_ff <= 1'b0;
            grpEnable_ff <= 2'h3;
        end else begin
            actChPrev_ff <= actCh;
            eopOe_n_ff <= nxt_eopOe_n;
            eopOut_ff <= nxt_eopOut;
            grpEnable_ff <= nxt_grpEnable;
        end
    end

    // Cycle length of the served channel; expansion-bus memory forces compatible
    wire dmc_pkg::dmc_timing_e effTiming =
        actIsaMem ? dmc_pkg::TM_COMPAT : cfg_ff[actCh].timing;
    logic [3:0] repLen;
    always_comb begin
        unique case (effTiming)
            dmc_pkg::TM_COMPAT: repLen = `DMC_CYC_COMPAT_REP;
            dmc_pkg::TM_A: repLen = `DMC_CYC_A_REP;
            dmc_pkg::TM_B: repLen = `DMC_CYC_B_REP;
            dmc_pkg::TM_F: repLen = `DMC_CYC_F_REP;
        endcase
    end
    // Only the compatible single cycle is fixed; fast singles add one clock
    wire [3:0] singleLen = (effTiming == dmc_pkg::TM_COMPAT) ? `DMC_CYC_COMPAT_SINGLE :
                           repLen + `DMC_CYC_FAST_SINGLE_EXTRA;
    wire [3:0] nxt_cycleLen = actRepeat ? repLen : singleLen;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cycleLen_ff <= `DMC_CYC_COMPAT_SINGLE;
        end else begin
            cycleLen_ff <= nxt_cycleLen;
        end
    end

    // Outputs, all straight from flip-flops
    assign chReq = chReq_ff;
    assign ackPin = ackPin_ff;
    assign grpRotate = rotate_ff;
    assign grpEnable = grpEnable_ff;
    assign chCfg = cfg_ff;
    assign strobeEn = strobeEn_ff;
    assign reloadPulse = reload_ff;
    assign eopOut = eopOut_ff;
    assign eopOe_n = eopOe_n_ff;
    assign cycleLen = cycleLen_ff;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_ch4_cascade: assert property (chCfg[4].mode == dmc_pkg::MD_CASCADE)
        else $error("channel four left cascade mode");
    a_mclr_mode_zero: assert property (masterClr |=> chCfg[0].mode == dmc_pkg::MD_DEMAND
        && !chCfg[0].addrDecr && !chCfg[0].autoInit && chCfg[0].xtype == dmc_pkg::TT_VERIFY)
        else $error("master clear did not clear channel mode");
    a_mclr_ext_kept: assert property (masterClr && !wrPop |=>
        $stable(chCfg[1].timing) && $stable(chCfg[1].eopIn) && $stable(chCfg[1].dataSize))
        else $error("master clear touched extended settings");
    a_upper_off_lower: assert property (!grpEnable[1] |-> !grpEnable[0])
        else $error("lower group enabled with upper group off");
    a_verify_no_strobe: assert property (strobeEn[1] |-> $past(chCfg[1].xtype) !=
        dmc_pkg::TT_VERIFY && $past(chCfg[1].mode) != dmc_pkg::MD_CASCADE)
        else $error("command strobes enabled for verify or cascade");
    a_reload_autoinit: assert property (reloadPulse[2] |-> $past(chCfg[2].autoInit))
        else $error("reload without autoinitialize");
    a_isamem_compat: assert property (actIsaMem && !actRepeat |=> cycleLen == 4'h9)
        else $error("expansion memory single cycle not nine clocks");
    a_type_f_len: assert property (!actIsaMem && actRepeat &&
        cfg_ff[actCh].timing == dmc_pkg::TM_F |=> cycleLen == 4'h3)
        else $error("type F repeated cycle not three clocks");
    a_mode_select: assert property (wrPop && wr.addr == `DMC_MODE_LO_ADDR &&
        wr.data[1:0] == 2'h1 && !masterClr |=> chCfg[1].addrDecr == $past(wr.data[5])
        && chCfg[1].mode == dmc_pkg::dmc_mode_e'($past(wr.data[7:6])))
        else $error("mode write did not land on selected channel");
    a_sense_low: assert property (senseLow_ff[0] && grpEnable_ff[0] && !reqSync_ff[0]
        |=> chReq[0])
        else $error("low-sensed request not seen");

    c_rotate: cover property (grpRotate == 2'h3);
    c_fifo_full: cover property (!ioWrReady ##1 ioWrReady);
    c_eop_switch: cover property (eopOe_n ##1 !eopOe_n);
    c_reload: cover property (|reloadPulse);

endmodule : dmc_channel_cfg

//--- dmc_slave_model.sv
/*
 * Stand-in for the expansion-bus DMA slaves: request pins and the shared
 * end-of-process line. Assumes the bench resolves that line from both sides.
 */
`timescale 1ns/10ps
module dmc_slave_model (
    input wire logic [7:0] reqOn,
    input wire logic [1:0] senseLow,
    input wire logic [7:0] ackPin,
    input wire logic [1:0] ackHigh,
    input wire logic [7:0] eopMode,
    input wire logic eopHit,
    output logic [7:0] dreqPin,
    output logic eopEn,
    output logic eopLvl
);
    // Group-wide level masks for requests and acknowledges
    wire logic [7:0] reqInv = {{4{senseLow[1]}}, {4{senseLow[0]}}};
    wire logic [7:0] ackPol = {{4{ackHigh[1]}}, {4{ackHigh[0]}}};
    // Acknowledge seen at this group's programmed level
    wire logic [7:0] ackSeen = ackPin ~^ ackPol;
    // Request pins at the level the group is set to sense
    assign dreqPin = reqOn ^ reqInv;
    // Drive only while our channel is acked and set for input
    assign eopEn = |(ackSeen & eopMode);
    // Idle at inactive low so any overlap with the device is harmless
    assign eopLvl = eopEn & eopHit;
endmodule : dmc_slave_model

//--- test_dma_channel_mode_config.sv
/*
 * Self-checking bench for the channel configuration block.
 * Assumes the package, FIFO, design and slave model are compiled first.
 */
`timescale 1ns/10ps
`include "dmc_cfg.svh"
module test_dma_channel_mode_config;
    // Port write and the setting it should leave on its channel
    typedef struct packed {
        logic [15:0] a;
        logic [7:0] d;
        logic [2:0] ch;
        logic [10:0] e;
    } dmc_row_s;
    logic ref_clk, rst, ioWrValid, ioWrReady, masterClr, xferBusy;
    logic eopPinIn, eopOut, eopOe_n, actRepeat, actIsaMem, eopEn, eopLvl, eopHit, idleInv;
    logic [15:0] ioAddr;
    logic [7:0] ioWrData, dreqPin, ackGrant, chReq, ackPin, strobeEn, tcPulse, reloadPulse;
    logic [7:0] reqOn, eopMode;
    logic [1:0] grpRotate, grpEnable, senseLow, ackHigh;
    logic [2:0] actCh;
    logic [3:0] cycleLen;
    dmc_pkg::dmc_chcfg_s [7:0] chCfg;
    int nErrors, nCompared, cyc, n;
    // Ordinary writes; the last one goes to an unmapped port
    dmc_row_s rows[11] = '{
        '{`DMC_MODE_LO_ADDR, 8'h95, 3'h1, 11'h4A0}, '{`DMC_MODE_LO_ADDR, 8'h4A, 3'h2, 11'h240},
        '{`DMC_MODE_LO_ADDR, 8'h23, 3'h3, 11'h100}, '{`DMC_MODE_LO_ADDR, 8'hC4, 3'h0, 11'h620},
        '{`DMC_MODE_HI_ADDR, 8'h54, 3'h4, 11'h6A1}, '{`DMC_MODE_HI_ADDR, 8'h89, 3'h5, 11'h441},
        '{`DMC_EXT_LO_ADDR, 8'h5D, 3'h1, 11'h4B7}, '{`DMC_EXT_HI_ADDR, 8'h22, 3'h6, 11'h008},
        '{`DMC_EXT_LO_ADDR, 8'h70, 3'h0, 11'h63C}, '{`DMC_EXT_HI_ADDR, 8'h17, 3'h7, 11'h005},
        '{16'h0010, 8'hFF, 3'h3, 11'h100}};
    // Channels set to compatible, A, B and F timing by the rows
    logic [2:0] cyCh[4] = '{3'h2, 3'h1, 3'h6, 3'h0};
    logic [3:0] cyRep[4] = '{4'h8, 4'h6, 4'h5, 4'h3};

    dmc_channel_cfg #(.FIFO_DEPTH(8)) u_dut (.ref_clk, .rst, .ioWrValid, .ioAddr, .ioWrData,
        .ioWrReady, .masterClr, .xferBusy, .dreqPin, .ackGrant, .chReq, .ackPin, .grpRotate,
        .grpEnable, .chCfg, .strobeEn, .tcPulse, .reloadPulse, .eopPinIn, .eopOut, .eopOe_n,
        .actCh, .actRepeat, .actIsaMem, .cycleLen);
    dmc_slave_model u_slv (.reqOn, .senseLow, .ackPin, .ackHigh, .eopMode, .eopHit, .dreqPin,
        .eopEn, .eopLvl);

    // A released line shows a changing level, never a held value
    assign eopPinIn = !eopOe_n ? eopOut : (eopEn ? eopLvl : idleInv);

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard, well above the fewer than two hundred cycles the run needs
    always @(posedge ref_clk) begin
        idleInv <= ~idleInv;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            nErrors++;
            endOfTest();
        end
    end

    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        nCompared++;
        if (g !== e) begin
            nErrors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Offer a write at a falling edge; return once it was taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        ioAddr = a;
        ioWrData = d;
        ioWrValid = 1'b1;
        while (ioWrReady !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
    endtask : wr

    task automatic idle(input int k);
        ioWrValid = 1'b0;
        repeat (k) @(negedge ref_clk);
    endtask : idle

    task automatic endOfTest();
        $display("compared %0d errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : endOfTest

    initial begin
        {rst, ioWrValid, masterClr, xferBusy, eopHit, actRepeat, actIsaMem, idleInv} = 8'h80;
        {ioAddr, ioWrData, ackGrant, tcPulse, reqOn, eopMode} = '0;
        {senseLow, ackHigh, actCh} = '0;
        {nErrors, nCompared, cyc} = '0;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        // Values left by reset
        for (int i = 0; i < 8; i++) chk(chCfg[i], {(i == 4) ? 2'h3 : 2'h0, 7'h00, (i > 3) ? 2'h1 : 2'h0});
        chk(11'({grpEnable, grpRotate}), 11'h00C);
        chk(11'(ackPin), 11'h0FF);
        chk(11'(cycleLen), 11'h009);
        chk(11'({chReq, strobeEn}), 11'h000);
        // Table of ordinary writes
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            idle(3);
            chk(chCfg[rows[i].ch], rows[i].e);
            chk(11'(strobeEn[rows[i].ch]), 11'(rows[i].e[10:9] != 2'h3 && rows[i].e[6:5] != 2'h0));
        end
        chk(chCfg[2], 11'h240);
        // Cycle lengths: repeated, single, and to expansion-bus memory
        for (int i = 0; i < 4; i++) begin
            actCh = cyCh[i];
            for (int r = 0; r < 3; r++) begin
                actRepeat = (r != 1);
                actIsaMem = (r == 2);
                idle(2);
                chk(11'(cycleLen), (r == 2) ? 11'h008 : 11'(cyRep[i]) + 11'(r == 1));
            end
        end
        // Low-level requests on the lower group, rotation on both, acknowledge polarity and disable on the upper
        reqOn = 8'h25;
        senseLow = 2'h1;
        wr(`DMC_CMD_LO_ADDR, 8'h50);
        idle(5);
        chk(11'(chReq), 11'h025);
        chk(11'(grpRotate), 11'h001);
        wr(`DMC_CMD_HI_ADDR, 8'h90);
        ackHigh = 2'h2;
        ackGrant = 8'h20;
        idle(3);
        chk(11'(ackPin), 11'h02F);
        chk(11'(grpRotate), 11'h003);
        ackGrant = 8'h00;
        wr(`DMC_CMD_HI_ADDR, 8'h84);
        idle(3);
        chk(11'(grpEnable), 11'h000);
        // Master clear keeps extended settings
        senseLow = 2'h0;
        ackHigh = 2'h0;
        masterClr = 1'b1;
        @(negedge ref_clk);
        masterClr = 1'b0;
        idle(5);
        chk(chCfg[1], 11'h017);
        chk(chCfg[4], 11'h601);
        chk(11'({grpEnable, grpRotate}), 11'h00C);
        chk(11'(chReq), 11'h025);
        chk(11'(ackPin), 11'h0FF);
        // Terminal count reloads only the autoinitialising channel
        wr(`DMC_MODE_LO_ADDR, 8'h11);
        idle(3);
        tcPulse = 8'h06;
        @(negedge ref_clk);
        tcPulse = 8'h00;
        chk(11'(reloadPulse), 11'h002);
        @(negedge ref_clk);
        chk(11'(reloadPulse), 11'h000);
        // Slave-driven end of process on an input channel
        eopMode = 8'h02;
        ackGrant = 8'h02;
        actCh = 3'h1;
        // The released line wanders until the slave sees its acknowledge;
        // let those stray edges drain before the counted window opens
        idle(4);
        chk(11'(eopOe_n), 11'h001);
        eopHit = 1'b1;
        n = 0;
        repeat (8) begin
            @(negedge ref_clk);
            n += reloadPulse[1];
        end
        chk(11'(n), 11'h001);
        eopHit = 1'b0;
        ackGrant = 8'h04;
        actCh = 3'h2;
        idle(2);
        chk(11'({eopOe_n, eopOut}), 11'h000);
        // Terminal count on a driving channel raises the output one cycle
        tcPulse = 8'h04;
        @(negedge ref_clk);
        tcPulse = 8'h00;
        chk(11'(eopOut), 11'h001);
        @(negedge ref_clk);
        chk(11'(eopOut), 11'h000);
        // Fill the FIFO while the engine stalls, then drain it
        xferBusy = 1'b1;
        for (int k = 0; k < 8; k++) wr(`DMC_EXT_LO_ADDR, {1'b0, 5'(k), 2'h3});
        ioWrData = 8'h23;
        repeat (3) @(negedge ref_clk);
        chk(11'(ioWrReady), 11'h000);
        chk(chCfg[3], 11'h000);
        xferBusy = 1'b0;
        wr(`DMC_EXT_LO_ADDR, 8'h23);
        idle(14);
        chk(chCfg[3], 11'h008);
        chk(11'(ioWrReady), 11'h001);
        // Only a reset brings the extended fields back to their defaults
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        chk(chCfg[1], 11'h000);
        chk(chCfg[6], 11'h001);
        chk(11'({eopOe_n, cycleLen}), 11'h009);
        endOfTest();
    end
endmodule : test_dma_channel_mode_config
